// *** rtcx_cap_stepper.sv ***
// Load capacitance stepper: walks the applied code toward the target.
// Assumes target is a stable register value from the register block.
`timescale 1ns/1ps
`default_nettype none

module rtcx_cap_stepper
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // control
  input wire logic step_enable,
  input wire logic [3:0] target,
  // status
  output logic [3:0] current,
  output logic settled
);

  typedef struct packed {
    logic [3:0] cur;
    logic [7:0] cnt;
    logic settled;
  } rtcx_step_state_t;

  rtcx_step_state_t s_r;
  rtcx_step_state_t s_nxt;

  localparam logic [7:0] LOAD_STEP_M1 = rtcx_pkg::LOAD_STEP_CYCLES - 8'h01;

  always_comb
  begin
    s_nxt = s_r;
    if (!step_enable)
    begin
      // stepping off: the target is applied in one go
      s_nxt.cur = target;
      s_nxt.cnt = 8'h00;
    end
    else if (s_r.cur != target)
    begin
      if (s_r.cnt == LOAD_STEP_M1)
      begin
        s_nxt.cnt = 8'h00;
        s_nxt.cur = (s_r.cur < target) ? s_r.cur + 4'h1 : s_r.cur - 4'h1;
      end
      else
      begin
        s_nxt.cnt = s_r.cnt + 8'h01;
      end
    end
    else
    begin
      s_nxt.cnt = 8'h00;
    end
    s_nxt.settled = (s_nxt.cur == target);
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r.cur <= rtcx_pkg::CFG_TARGET_RESET;
      s_r.cnt <= 8'h00;
      s_r.settled <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign current = s_r.cur;
  assign settled = s_r.settled;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_SETTLED_MEANS_EQUAL: assert property (
    settled |-> current == $past(target)
  ) else $error("settled flag high while capacitance differs from target");

  AST_STEP_ONE_AT_A_TIME: assert property (
    (step_enable && $past(step_enable) && current != $past(current))
      |-> (current == $past(current) + 4'h1 || current == $past(current) - 4'h1)
  ) else $error("automatic stepping moved capacitance by more than one code");

endmodule

`default_nettype wire

// *** rtcx_osc_regs.sv ***
// RTC oscillator control, load capacitance and timer transfer registers.
// Assumes an APB master on the same clock; the timer itself lies outside,
// delivering its count and taking a load strobe with a 32-bit value.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module rtcx_osc_regs
(
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // register bus
  input wire rtcx_pkg::rtcx_apb_req_t apb_req,
  output var rtcx_pkg::rtcx_apb_rsp_t apb_rsp,
  // oscillator analog side
  input wire logic osc_amplitude_valid,
  output var rtcx_pkg::rtcx_osc_ctl_t osc_ctl,
  // timer
  input wire logic [31:0] timer_count,
  output logic [31:0] timer_load_value,
  output logic timer_load_strobe,
  // request bits visible for the core
  output logic timer_set_request,
  output logic timer_capture_request
);

  typedef struct packed {
    logic [3:0][7:0] xfer;
    logic gain;
    logic xtal;
    logic bias;
    logic slow;
    logic step_en;
    logic [3:0] target;
    logic short_pins;
    logic [6:0] pin_rsvd;
    logic set_req;
    logic cap_req;
    rtcx_pkg::rtcx_xfer_state_t fsm;
    logic [31:0] load_value;
    logic load_strobe;
    logic [7:0] prdata;
  } rtcx_regs_state_t;

  rtcx_regs_state_t s_r;
  rtcx_regs_state_t s_nxt;

  logic [3:0] cap_current;
  logic cap_settled;

  // word aligned and inside the eight-word window
  function automatic logic addr_hit(input logic [7:0] addr);
    return (addr[1:0] == 2'h0) && (addr[7:5] == 3'h0);
  endfunction

  function automatic logic [2:0] addr_index(input logic [7:0] addr);
    return addr[4:2];
  endfunction

  logic bus_setup;
  logic bus_access;
  logic bus_write;
  logic [2:0] bus_idx;
  logic [7:0] wbyte;

  assign bus_setup = apb_req.psel && !apb_req.penable;
  assign bus_access = apb_req.psel && apb_req.penable;
  assign bus_write = bus_access && apb_req.pwrite && addr_hit(apb_req.paddr);
  assign bus_idx = addr_index(apb_req.paddr);
  assign wbyte = apb_req.pwdata[7:0];

  // read view of one register
  function automatic logic [7:0] read_mux(input rtcx_regs_state_t s,
                                          input logic [2:0] idx,
                                          input logic amp_ok,
                                          input logic cap_ok);
    logic [7:0] v;
    v = 8'h00;
    if (idx <= rtcx_pkg::IDX_XFER3)
    begin
      v = s.xfer[idx[1:0]];
    end
    else if (idx == rtcx_pkg::IDX_REQUEST)
    begin
      v[rtcx_pkg::REQ_SET_BIT] = s.set_req;
      v[rtcx_pkg::REQ_CAP_BIT] = s.cap_req;
    end
    else if (idx == rtcx_pkg::IDX_CONTROL)
    begin
      v[rtcx_pkg::CTRL_GAIN_BIT] = s.gain;
      v[rtcx_pkg::CTRL_XTAL_BIT] = s.xtal;
      v[rtcx_pkg::CTRL_BIAS_BIT] = s.bias;
      v[rtcx_pkg::CTRL_AMP_BIT] = amp_ok;
      v[rtcx_pkg::CTRL_SLOW_BIT] = s.slow;
      // bits 2:0 stay zero
    end
    else if (idx == rtcx_pkg::IDX_CONFIG)
    begin
      v[rtcx_pkg::CFG_STEP_BIT] = s.step_en;
      v[rtcx_pkg::CFG_SETTLED_BIT] = cap_ok;
      v[rtcx_pkg::CFG_TARGET_MSB:0] = s.target;
    end
    else
    begin
      // short bit is write-only and reads zero
      v[rtcx_pkg::PIN_RSVD_MSB:0] = s.pin_rsvd;
    end
    return v;
  endfunction

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.load_strobe = 1'b0;

    // transfer engine; set takes priority when both are pending
    unique case (s_r.fsm)
      rtcx_pkg::XFER_IDLE:
      begin
        if (s_r.set_req)
        begin
          s_nxt.load_value = s_r.xfer;
          s_nxt.load_strobe = 1'b1;
          s_nxt.fsm = rtcx_pkg::XFER_LOAD;
        end
        else if (s_r.cap_req)
        begin
          s_nxt.xfer = timer_count;
          s_nxt.fsm = rtcx_pkg::XFER_CAPTURE;
        end
      end
      rtcx_pkg::XFER_LOAD:
      begin
        s_nxt.set_req = 1'b0;
        s_nxt.fsm = rtcx_pkg::XFER_IDLE;
      end
      rtcx_pkg::XFER_CAPTURE:
      begin
        s_nxt.cap_req = 1'b0;
        s_nxt.fsm = rtcx_pkg::XFER_IDLE;
      end
      default:
      begin
        s_nxt.fsm = rtcx_pkg::XFER_IDLE;
      end
    endcase

    // bus writes come last so a fresh request beats the hardware clear
    if (bus_write)
    begin
      if (bus_idx <= rtcx_pkg::IDX_XFER3)
      begin
        s_nxt.xfer[bus_idx[1:0]] = wbyte;
      end
      else if (bus_idx == rtcx_pkg::IDX_REQUEST)
      begin
        if (wbyte[rtcx_pkg::REQ_SET_BIT])
        begin
          s_nxt.set_req = 1'b1;
        end
        if (wbyte[rtcx_pkg::REQ_CAP_BIT])
        begin
          s_nxt.cap_req = 1'b1;
        end
      end
      else if (bus_idx == rtcx_pkg::IDX_CONTROL)
      begin
        s_nxt.gain = wbyte[rtcx_pkg::CTRL_GAIN_BIT];
        s_nxt.xtal = wbyte[rtcx_pkg::CTRL_XTAL_BIT];
        s_nxt.bias = wbyte[rtcx_pkg::CTRL_BIAS_BIT];
        s_nxt.slow = wbyte[rtcx_pkg::CTRL_SLOW_BIT];
      end
      else if (bus_idx == rtcx_pkg::IDX_CONFIG)
      begin
        s_nxt.step_en = wbyte[rtcx_pkg::CFG_STEP_BIT];
        s_nxt.target = wbyte[rtcx_pkg::CFG_TARGET_MSB:0];
      end
      else
      begin
        s_nxt.short_pins = wbyte[rtcx_pkg::PIN_SHORT_BIT];
        // reserved bits kept as written, so read-modify-write round-trips
        s_nxt.pin_rsvd = wbyte[rtcx_pkg::PIN_RSVD_MSB:0];
      end
    end

    // read data is latched in the setup cycle so prdata comes from a flop
    if (bus_setup)
    begin
      s_nxt.prdata = addr_hit(apb_req.paddr)
        ? read_mux(s_r, bus_idx, osc_amplitude_valid, cap_settled)
        : 8'h00;
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s_r.xfer <= {4{rtcx_pkg::XFER_RESET}};
      s_r.gain <= rtcx_pkg::CTRL_RESET[rtcx_pkg::CTRL_GAIN_BIT];
      s_r.xtal <= rtcx_pkg::CTRL_RESET[rtcx_pkg::CTRL_XTAL_BIT];
      s_r.bias <= rtcx_pkg::CTRL_RESET[rtcx_pkg::CTRL_BIAS_BIT];
      s_r.slow <= rtcx_pkg::CTRL_RESET[rtcx_pkg::CTRL_SLOW_BIT];
      s_r.step_en <= 1'b0;
      s_r.target <= rtcx_pkg::CFG_TARGET_RESET;
      s_r.short_pins <= 1'b0;
      s_r.pin_rsvd <= rtcx_pkg::PIN_RSVD_RESET;
      s_r.set_req <= 1'b0;
      s_r.cap_req <= 1'b0;
      s_r.fsm <= rtcx_pkg::XFER_IDLE;
      s_r.load_value <= 32'h00000000;
      s_r.load_strobe <= 1'b0;
      s_r.prdata <= 8'h00;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  rtcx_cap_stepper u_stepper
  (
    .clock(clock),
    .rst(rst),
    .step_enable(s_r.step_en),
    .target(s_r.target),
    .current(cap_current),
    .settled(cap_settled)
  );

  // bus answers with no wait state; unmapped words raise pslverr
  // one driver for the whole response struct
  assign apb_rsp = '{prdata: {24'h000000, s_r.prdata},
                     pready: 1'b1,
                     pslverr: bus_access && !addr_hit(apb_req.paddr)};

  // slow oscillator overrides the crystal/self choice
  always_comb
  begin
    osc_ctl.gain_control_enable = s_r.gain;
    osc_ctl.osc_source_crystal_select = s_r.xtal;
    osc_ctl.bias_double_enable = s_r.bias;
    osc_ctl.internal_slow_osc_select = s_r.slow;
    if (s_r.slow)
    begin
      osc_ctl.osc_source = rtcx_pkg::OSC_SRC_SLOW;
    end
    else if (s_r.xtal)
    begin
      osc_ctl.osc_source = rtcx_pkg::OSC_SRC_CRYSTAL;
    end
    else
    begin
      osc_ctl.osc_source = rtcx_pkg::OSC_SRC_SELF;
    end
    osc_ctl.load_cap_auto_step_enable = s_r.step_en;
    osc_ctl.load_cap_current = cap_current;
    osc_ctl.xtal_pins_short = s_r.short_pins;
  end

  assign timer_load_value = s_r.load_value;
  assign timer_load_strobe = s_r.load_strobe;
  assign timer_set_request = s_r.set_req;
  assign timer_capture_request = s_r.cap_req;

  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  logic wr_ctrl;
  logic wr_cfg;
  logic rd_ctrl;
  logic rd_cfg;
  assign wr_ctrl = bus_write && bus_idx == rtcx_pkg::IDX_CONTROL;
  assign wr_cfg = bus_write && bus_idx == rtcx_pkg::IDX_CONFIG;
  assign rd_ctrl = bus_setup && addr_hit(apb_req.paddr) && bus_idx == rtcx_pkg::IDX_CONTROL;
  assign rd_cfg = bus_setup && addr_hit(apb_req.paddr) && bus_idx == rtcx_pkg::IDX_CONFIG;

  AST_GAIN_FOLLOWS_WRITE: assert property (
    wr_ctrl |=> osc_ctl.gain_control_enable == $past(apb_req.pwdata[7])
  ) else $error("gain control enable does not follow control write");

  AST_CRYSTAL_SELECTED: assert property (
    (wr_ctrl && apb_req.pwdata[6] && !apb_req.pwdata[3])
      |=> osc_ctl.osc_source == rtcx_pkg::OSC_SRC_CRYSTAL
  ) else $error("crystal mode not selected after control write");

  AST_BIAS_FOLLOWS_WRITE: assert property (
    wr_ctrl |=> osc_ctl.bias_double_enable == $past(apb_req.pwdata[5])
  ) else $error("bias doubling does not follow control write");

  AST_AMPLITUDE_READ: assert property (
    rd_ctrl |=> apb_rsp.prdata[4] == $past(osc_amplitude_valid)
  ) else $error("amplitude valid bit reads wrong value");

  AST_SLOW_OVERRIDES: assert property (
    (wr_ctrl && apb_req.pwdata[3]) |=> osc_ctl.osc_source == rtcx_pkg::OSC_SRC_SLOW
  ) else $error("slow oscillator does not override source select");

  AST_CTRL_LOW_ZERO: assert property (
    rd_ctrl |=> apb_rsp.prdata[2:0] == 3'h0
  ) else $error("control low bits read nonzero");

  AST_STEP_ENABLE_WRITE: assert property (
    wr_cfg |=> osc_ctl.load_cap_auto_step_enable == $past(apb_req.pwdata[7])
  ) else $error("auto step enable does not follow config write");

  AST_SETTLED_READ: assert property (
    rd_cfg |=> apb_rsp.prdata[6] == $past(cap_settled) && apb_rsp.prdata[5:4] == 2'h0
  ) else $error("config settled or unused bits read wrong");

  AST_PIN_SHORT: assert property (
    (bus_write && bus_idx == rtcx_pkg::IDX_PINS)
      |=> osc_ctl.xtal_pins_short == $past(apb_req.pwdata[7])
  ) else $error("pin short does not follow pin write");

  AST_SET_LOADS_TIMER: assert property (
    (s_r.fsm == rtcx_pkg::XFER_IDLE && s_r.set_req)
      |=> timer_load_strobe && timer_load_value == $past(s_r.xfer)
      ##1 !timer_load_strobe && (!timer_set_request || $past(bus_write))
  ) else $error("set request did not load timer and clear");

  AST_CAPTURE_COPIES: assert property (
    (s_r.fsm == rtcx_pkg::XFER_IDLE && !s_r.set_req && s_r.cap_req && !bus_write)
      |=> s_r.xfer == $past(timer_count) ##1 (!timer_capture_request || $past(bus_write))
  ) else $error("capture request did not copy timer and clear");

  AST_NO_STRAY_LOAD: assert property (
    timer_load_strobe |-> $past(s_r.set_req)
  ) else $error("timer loaded without a set request");

  COV_SET: cover property (s_r.set_req ##1 timer_load_strobe ##1 !timer_set_request);
  COV_CAPTURE: cover property (s_r.fsm == rtcx_pkg::XFER_CAPTURE ##1 !timer_capture_request);
  COV_SLVERR: cover property (apb_rsp.pslverr);
  COV_STEP_SETTLE: cover property (!cap_settled ##1 cap_settled);

endmodule

`default_nettype wire

// *** rtcx_pkg.sv ***
// Constants, enumerations and carrier types for the RTC oscillator and
// timer-transfer register block.
// Assumes APB with 32-bit data; each 8-bit register sits in the low byte of
// one aligned word at byte address four times its register index.
//
// Overview of operation
// - control bit 7 turns automatic gain control on (1) or off (0).
// - control bit 6 picks the source: 0 self-oscillate, 1 crystal.
// - control bit 5 turns bias doubling on (1) or off (0).
// - control bit 4 reads 1 only while oscillation amplitude is sufficient.
// - control bit 3 set selects the internal slow oscillator, overriding bit 6.
// - control bits 2:0 always read zero; writes to them do nothing.
// - configuration bit 7 enables automatic load capacitance stepping.
// - configuration bit 6 reads 1 once actual load capacitance equals target.
// - configuration bits 3:0 hold the programmed load capacitance target.
// - configuration bits 5:4 read zero and ignore writes.
// - write-only pin bit 7 shorts the two crystal pins when 1.
// - four byte registers form one 32-bit timer transfer buffer.
// - buffer and timer exchange data only on set or capture requests.
// - buffer byte at index 0 is least significant; higher indices more significant.
// - buffer at indices 0 to 3, reset zero; control 5, config 6, pins 7.
// - writing 1 to set request loads timer; hardware clears it when done.
// - writing 1 to capture request copies timer; hardware clears it when done.

package rtcx_pkg;

  // register indices; byte address is four times the index
  localparam logic [2:0] IDX_XFER0 = 3'h0;
  localparam logic [2:0] IDX_XFER3 = 3'h3;
  localparam logic [2:0] IDX_REQUEST = 3'h4;
  localparam logic [2:0] IDX_CONTROL = 3'h5;
  localparam logic [2:0] IDX_CONFIG = 3'h6;
  localparam logic [2:0] IDX_PINS = 3'h7;

  // control register fields
  localparam int unsigned CTRL_GAIN_BIT = 7;
  localparam int unsigned CTRL_XTAL_BIT = 6;
  localparam int unsigned CTRL_BIAS_BIT = 5;
  localparam int unsigned CTRL_AMP_BIT = 4;
  localparam int unsigned CTRL_SLOW_BIT = 3;

  // configuration register fields
  localparam int unsigned CFG_STEP_BIT = 7;
  localparam int unsigned CFG_SETTLED_BIT = 6;
  localparam int unsigned CFG_TARGET_MSB = 3;

  // pin register and request register fields
  localparam int unsigned PIN_SHORT_BIT = 7;
  localparam int unsigned PIN_RSVD_MSB = 6;
  localparam int unsigned REQ_SET_BIT = 1;
  localparam int unsigned REQ_CAP_BIT = 0;

  // reset values
  localparam logic [7:0] XFER_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] CFG_TARGET_RESET = 4'h0;
  localparam logic [6:0] PIN_RSVD_RESET = 7'h00;

  // clock cycles between two load capacitance steps
  localparam logic [7:0] LOAD_STEP_CYCLES = 8'h40;

  typedef enum logic [1:0] {
    OSC_SRC_SELF,
    OSC_SRC_CRYSTAL,
    OSC_SRC_SLOW
  } rtcx_osc_src_t;

  typedef enum logic [1:0] {
    XFER_IDLE,
    XFER_LOAD,
    XFER_CAPTURE
  } rtcx_xfer_state_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } rtcx_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rtcx_apb_rsp_t;

  typedef struct packed {
    logic gain_control_enable;
    logic osc_source_crystal_select;
    logic bias_double_enable;
    logic internal_slow_osc_select;
    rtcx_osc_src_t osc_source;
    logic load_cap_auto_step_enable;
    logic [3:0] load_cap_current;
    logic xtal_pins_short;
  } rtcx_osc_ctl_t;

endpackage

// *** tb_rtcx_osc_regs.sv ***
// Self-checking bench for the oscillator and timer transfer register block.
// Assumes the block answers on APB; the bench plays the core and the timer.
`timescale 1ns/1ps
`default_nettype none

module tb_rtcx_osc_regs;
  logic clock;
  logic rst;
  rtcx_pkg::rtcx_apb_req_t req;
  rtcx_pkg::rtcx_apb_rsp_t rsp;
  logic amp_valid;
  rtcx_pkg::rtcx_osc_ctl_t osc_ctl;
  logic [31:0] timer_count;
  logic [31:0] load_value;
  logic load_strobe;
  logic set_req;
  logic cap_req;
  int n_mismatch;
  int n_compared;
  logic [31:0] rd;
  logic err;
  logic [7:0] ctl_vals [4];
  logic [7:0] v;
  logic [31:0] exp_word;
  int k;

  rtcx_osc_regs dut
  (
    .clock(clock),
    .rst(rst),
    .apb_req(req),
    .apb_rsp(rsp),
    .osc_amplitude_valid(amp_valid),
    .osc_ctl(osc_ctl),
    .timer_count(timer_count),
    .timer_load_value(load_value),
    .timer_load_strobe(load_strobe),
    .timer_set_request(set_req),
    .timer_capture_request(cap_req)
  );

  always #12.5 clock = ~clock;

  task results;
    if (n_mismatch == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  // one full transfer; pready, read data and pslverr are taken at the completing edge
  task apb(input logic wr, input logic [7:0] addr, input logic [7:0] wd);
    int i;
    @(posedge clock);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= wr;
    req.paddr <= addr;
    req.pwdata <= {24'h000000, wd};
    @(posedge clock);
    req.penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge clock);
      if (rsp.pready === 1'b1)
        break;
    end
    if (rsp.pready !== 1'b1)
    begin
      n_mismatch++;
      $display("wrong value at %0t: transfer never completed", $time);
      results();
    end
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // register index times four is the byte address
  task wreg(input logic [2:0] idx, input logic [7:0] d);
    apb(1'b1, {3'h0, idx, 2'h0}, d);
  endtask

  task rreg(input logic [2:0] idx);
    apb(1'b0, {3'h0, idx, 2'h0}, 8'h00);
  endtask

  // bounded wait on a settled status: 0 strobe, 1 set clear, 2 capture clear, 3 cap code
  task wait_for(input int sel, input int bound, input logic [3:0] code);
    int i;
    logic hit;
    hit = 1'b0;
    for (i = 0; i < bound && !hit; i++)
    begin
      @(negedge clock);
      case (sel)
        0: hit = (load_strobe === 1'b1);
        1: hit = (set_req === 1'b0);
        2: hit = (cap_req === 1'b0);
        default: hit = (osc_ctl.load_cap_current === code);
      endcase
    end
    if (!hit)
    begin
      n_mismatch++;
      $display("wrong value at %0t: wait %0d ran out", $time, sel);
      results();
    end
    // back on a rising edge so the next stimulus lands there
    @(posedge clock);
  endtask

  initial
  begin
    clock = 1'b0;
    rst = 1'b1;
    req = '0;
    amp_valid = 1'b0;
    timer_count = 32'h00000000;
    n_mismatch = 0;
    n_compared = 0;
    ctl_vals = '{8'h00, 8'h47, 8'hC8, 8'hA7};
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    // reset values of the buffer, control and pin registers
    for (k = 0; k < 4; k++)
    begin
      rreg(k[2:0]);
      chk(rd, 32'h00000000);
    end
    rreg(rtcx_pkg::IDX_CONTROL);
    chk(rd, 32'h00000000);
    rreg(rtcx_pkg::IDX_PINS);
    chk(rd, 32'h00000000);
    // control bits drive the oscillator; low bits never read back
    for (k = 0; k < 4; k++)
    begin
      v = ctl_vals[k];
      amp_valid <= k[0];
      wreg(rtcx_pkg::IDX_CONTROL, v);
      @(negedge clock);
      chk(osc_ctl.gain_control_enable, v[7]);
      chk(osc_ctl.osc_source_crystal_select, v[6]);
      chk(osc_ctl.bias_double_enable, v[5]);
      chk(osc_ctl.internal_slow_osc_select, v[3]);
      chk(osc_ctl.osc_source, v[3] ? rtcx_pkg::OSC_SRC_SLOW :
          (v[6] ? rtcx_pkg::OSC_SRC_CRYSTAL : rtcx_pkg::OSC_SRC_SELF));
      rreg(rtcx_pkg::IDX_CONTROL);
      chk(rd & 32'h000000F7, {24'h000000, v[7:5], k[0], 4'h0});
    end
    // stepping off: code jumps, reserved bits stay zero
    wreg(rtcx_pkg::IDX_CONFIG, 8'h3A);
    repeat (3) @(negedge clock);
    chk(osc_ctl.load_cap_current, 4'hA);
    chk(osc_ctl.load_cap_auto_step_enable, 1'b0);
    rreg(rtcx_pkg::IDX_CONFIG);
    chk(rd, 32'h0000004A);
    // stepping on: not settled until the code walks to the target
    wreg(rtcx_pkg::IDX_CONFIG, 8'hB3);
    rreg(rtcx_pkg::IDX_CONFIG);
    chk(rd, 32'h00000083);
    chk(osc_ctl.load_cap_auto_step_enable, 1'b1);
    wait_for(3, 1000, 4'h3);
    repeat (3) @(negedge clock);
    rreg(rtcx_pkg::IDX_CONFIG);
    chk(rd, 32'h000000C3);
    // pin short is write-only; reserved bits kept by read-modify-write
    wreg(rtcx_pkg::IDX_PINS, 8'h55);
    @(negedge clock);
    chk(osc_ctl.xtal_pins_short, 1'b0);
    rreg(rtcx_pkg::IDX_PINS);
    wreg(rtcx_pkg::IDX_PINS, rd[7:0] | 8'h80);
    @(negedge clock);
    chk(osc_ctl.xtal_pins_short, 1'b1);
    rreg(rtcx_pkg::IDX_PINS);
    chk(rd, 32'h00000055);
    // buffer loads the timer only on a set request
    exp_word = 32'h44332211;
    for (k = 0; k < 4; k++)
      wreg(k[2:0], exp_word[8*k+:8]);
    chk(load_strobe, 1'b0);
    wreg(rtcx_pkg::IDX_REQUEST, 8'h02);
    wait_for(0, 10, 4'h0);
    chk(load_value, exp_word);
    wait_for(1, 10, 4'h0);
    // capture copies the live count; later changes leave the buffer alone
    timer_count <= 32'hA1B2C3D4;
    wreg(rtcx_pkg::IDX_REQUEST, 8'h01);
    wait_for(2, 10, 4'h0);
    timer_count <= 32'h0F0E0D0C;
    chk(load_strobe, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      exp_word = 32'hA1B2C3D4;
      rreg(k[2:0]);
      chk(rd, {24'h000000, exp_word[8*k+:8]});
    end
    // both requests at once: set loads the old buffer first, then capture refills it
    wreg(rtcx_pkg::IDX_REQUEST, 8'h03);
    wait_for(0, 10, 4'h0);
    chk(load_value, 32'hA1B2C3D4);
    wait_for(1, 10, 4'h0);
    wait_for(2, 10, 4'h0);
    rreg(3'h0);
    chk(rd, 32'h0000000C);
    // unmapped and misaligned places are refused
    apb(1'b0, 8'h20, 8'h00);
    chk({err, rd}, {1'b1, 32'h00000000});
    apb(1'b1, 8'h15, 8'hFF);
    chk(err, 1'b1);
    rreg(rtcx_pkg::IDX_CONTROL);
    chk(rd & 32'h000000F7, 32'h000000B0);
    // second reset in mid-run clears the buffer again
    @(posedge clock);
    rst <= 1'b1;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    rreg(3'h3);
    chk(rd, 32'h00000000);
    chk({set_req, cap_req, load_strobe}, 3'h0);
    results();
  end
endmodule

`default_nettype wire
